// ===== hdl/twfp_device.sv
// Purpose: target end of the link, unlock and flash command sequencer
// Assumes: flash array answers each request with one flash_ack pulse
// Notes: host must poll busy before the next data-register byte
`timescale 1ns/1ps
module twfp_device (
	// link pins
	twfp_link_if.device link,
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// debug state
	input wire logic halted,
	output logic pins_borrowed,
	output logic prog_unlocked,
	// flash array
	output logic flash_req,
	output twfp_pkg::twfp_op_t flash_op,
	output logic [15:0] flash_addr,
	output logic [7:0] flash_wdata,
	input wire logic [7:0] flash_rdata,
	input wire logic flash_ack
);
	import twfp_pkg::*;

	typedef enum logic [1:0] {TWFP_L_IDLE, TWFP_L_INS, TWFP_L_RX, TWFP_L_TX} twfp_lst_t;
	typedef enum logic [1:0] {TWFP_U_LOCKED, TWFP_U_HALF, TWFP_U_OPEN} twfp_ust_t;
	typedef enum logic [2:0] {TWFP_C_CMD, TWFP_C_AHI, TWFP_C_ALO, TWFP_C_LEN, TWFP_C_DATA} twfp_cst_t;

	logic clk_s;
	logic dat_s;
	logic clk_prev_q;
	twfp_lst_t lst_q;
	twfp_ust_t ust_q;
	twfp_ust_t ust_d;
	twfp_cst_t cst_q;
	twfp_op_t op_q;
	logic [3:0] bcnt_q;
	logic [1:0] ins_q;
	logic [7:0] sh_q;
	logic oe_q;
	logic do_q;
	logic [7:0] sel_q;
	logic [7:0] data_q;
	logic [15:0] addr_q;
	logic [8:0] len_q;
	logic busy_q;
	logic req_q;
	logic [7:0] wdata_q;
	logic pins_q;
	logic [7:0] ctrl_rd;

	// reset pin only ever sampled, never driven
	twfp_sync #(.INIT(1'b1)) u_clk_sync (.mclk(mclk), .rst_b(rst_b), .din(link.link_clock_line), .dout(clk_s));
	twfp_sync #(.INIT(1'b1)) u_dat_sync (.mclk(mclk), .rst_b(rst_b), .din(link.link_data_line), .dout(dat_s));

	wire rise = clk_s & ~clk_prev_q;
	wire fall = ~clk_s & clk_prev_q;
	wire bit_last = (bcnt_q == 4'h1);
	wire [1:0] ins_next = {ins_q[0], dat_s};
	wire [7:0] rx_byte = {sh_q[6:0], dat_s};
	wire rx_done = halted && (lst_q == TWFP_L_RX) && rise && bit_last;
	wire tx_done = halted && (lst_q == TWFP_L_TX) && rise && bit_last;
	wire unlocked = (ust_q == TWFP_U_OPEN);
	// select register steers data reads and writes
	wire wr_sel = rx_done && (ins_q == INS_ADDR_WRITE);
	wire wr_ctrl = rx_done && (ins_q == INS_DATA_WRITE) && (sel_q == SEL_CTRL);
	wire wr_data = rx_done && (ins_q == INS_DATA_WRITE) && (sel_q == SEL_DATA);
	wire rd_data = tx_done && (ins_q == INS_DATA_READ) && (sel_q == SEL_DATA);
	// flash bytes accepted only once unlocked and idle
	wire cmd_wr = wr_data && unlocked && !busy_q;
	wire rd_adv = rd_data && unlocked && !busy_q && (cst_q == TWFP_C_DATA) && (op_q == TWFP_OP_READ);
	wire wr_adv = flash_ack && (cst_q == TWFP_C_DATA) && (op_q == TWFP_OP_WRITE);
	wire len_last = (len_q == 9'h001);
	wire [15:0] addr_inc = 16'(addr_q + 16'h0001);
	wire [8:0] len_dec = 9'(len_q - 9'h001);

	always_comb begin
		ctrl_rd = 8'h00;
		ctrl_rd[CTRL_UNLOCK_BIT] = unlocked;
		ctrl_rd[CTRL_BUSY_BIT] = busy_q;
	end

	wire [7:0] reg_rd = (sel_q == SEL_PART_ID) ? PART_ID_VALUE :
		(sel_q == SEL_REV_ID) ? REV_ID_VALUE :
		(sel_q == SEL_CTRL) ? ctrl_rd :
		(sel_q == SEL_DATA) ? data_q : 8'h00;
	wire [7:0] tx_byte = (ins_next == INS_ADDR_READ) ? sel_q : reg_rd;

	// only an ordered 0x02, 0x01 opens; anything else restarts
	// open is terminal: only rst_b leaves it
	assign ust_d = (ust_q == TWFP_U_OPEN) ? TWFP_U_OPEN :
		(rx_byte == UNLOCK_FIRST) ? TWFP_U_HALF :
		((ust_q == TWFP_U_HALF) && (rx_byte == UNLOCK_SECOND)) ? TWFP_U_OPEN : TWFP_U_LOCKED;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			clk_prev_q <= 1'b1;
			pins_q <= 1'b0;
			sel_q <= 8'h00;
			ust_q <= TWFP_U_LOCKED;
		end else begin
			clk_prev_q <= clk_s;
			pins_q <= halted;
			if (wr_sel) begin
				sel_q <= rx_byte;
			end
			if (wr_ctrl) begin
				ust_q <= ust_d;
			end
		end
	end

	// link framing, active only while halted
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			lst_q <= TWFP_L_IDLE;
			bcnt_q <= 4'h0;
			ins_q <= 2'h0;
			sh_q <= 8'h00;
			oe_q <= 1'b0;
			do_q <= 1'b1;
		end else if (!halted) begin
			lst_q <= TWFP_L_IDLE;
			oe_q <= 1'b0;
		end else begin
			case (lst_q)
				TWFP_L_IDLE: begin
					if (rise && !dat_s) begin
						lst_q <= TWFP_L_INS;
						bcnt_q <= INS_BITS;
					end
				end
				TWFP_L_INS: begin
					if (rise) begin
						ins_q <= ins_next;
						bcnt_q <= bcnt_q - 4'h1;
						if (bit_last) begin
							bcnt_q <= BYTE_BITS;
							if (ins_next[0]) begin
								lst_q <= TWFP_L_RX;
							end else begin
								lst_q <= TWFP_L_TX;
								sh_q <= tx_byte;
							end
						end
					end
				end
				TWFP_L_RX: begin
					if (rise) begin
						sh_q <= rx_byte;
						bcnt_q <= bcnt_q - 4'h1;
						if (bit_last) begin
							lst_q <= TWFP_L_IDLE;
						end
					end
				end
				default: begin
					// change data after the fall so it is settled for the host's rise
					if (fall) begin
						oe_q <= 1'b1;
						do_q <= sh_q[7];
						sh_q <= {sh_q[6:0], 1'b0};
					end
					if (rise) begin
						bcnt_q <= bcnt_q - 4'h1;
						if (bit_last) begin
							lst_q <= TWFP_L_IDLE;
							oe_q <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	// flash command stream through the data register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cst_q <= TWFP_C_CMD;
			op_q <= TWFP_OP_READ;
			addr_q <= 16'h0000;
			len_q <= 9'h000;
			busy_q <= 1'b0;
			req_q <= 1'b0;
			wdata_q <= 8'h00;
			data_q <= 8'h00;
		end else begin
			req_q <= 1'b0;
			if (flash_ack) begin
				busy_q <= 1'b0;
				if (op_q == TWFP_OP_READ) begin
					data_q <= flash_rdata;
				end
			end
			if (wr_adv || rd_adv) begin
				addr_q <= addr_inc;
				len_q <= len_dec;
				if (len_last) begin
					cst_q <= TWFP_C_CMD;
				end else if (rd_adv) begin
					req_q <= 1'b1;
					busy_q <= 1'b1;
				end
			end
			if (cmd_wr) begin
				case (cst_q)
					TWFP_C_CMD: begin
						if (rx_byte == OPC_BLOCK_READ) begin
							op_q <= TWFP_OP_READ;
							cst_q <= TWFP_C_AHI;
						end else if (rx_byte == OPC_BLOCK_WRITE) begin
							op_q <= TWFP_OP_WRITE;
							cst_q <= TWFP_C_AHI;
						end else if (rx_byte == OPC_PAGE_ERASE) begin
							op_q <= TWFP_OP_PAGE_ERASE;
							cst_q <= TWFP_C_AHI;
						end else if (rx_byte == OPC_DEVICE_ERASE) begin
							op_q <= TWFP_OP_DEV_ERASE;
							req_q <= 1'b1;
							busy_q <= 1'b1;
						end
					end
					TWFP_C_AHI: begin
						addr_q[15:8] <= rx_byte;
						cst_q <= TWFP_C_ALO;
					end
					TWFP_C_ALO: begin
						addr_q[7:0] <= rx_byte;
						if (op_q == TWFP_OP_PAGE_ERASE) begin
							req_q <= 1'b1;
							busy_q <= 1'b1;
							cst_q <= TWFP_C_CMD;
						end else begin
							cst_q <= TWFP_C_LEN;
						end
					end
					TWFP_C_LEN: begin
						len_q <= (rx_byte == 8'h00) ? BLOCK_FULL : {1'b0, rx_byte};
						cst_q <= TWFP_C_DATA;
						if (op_q == TWFP_OP_READ) begin
							req_q <= 1'b1;
							busy_q <= 1'b1;
						end
					end
					default: begin
						// bytes written during a block read are dropped
						if (op_q == TWFP_OP_WRITE) begin
							wdata_q <= rx_byte;
							req_q <= 1'b1;
							busy_q <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	assign link.dev_dout = do_q;
	assign link.dev_oe = oe_q;
	assign pins_borrowed = pins_q;
	assign prog_unlocked = unlocked;
	assign flash_req = req_q;
	assign flash_op = op_q;
	assign flash_addr = addr_q;
	assign flash_wdata = wdata_q;
endmodule

// ===== hdl/twfp_pkg.sv
// Purpose: shared constants and types for the two-wire flash programming link
// Assumes: mclk at 100 MHz on both ends
// Notes: frame = start bit, 2 instruction bits, 8 data bits, msb first
//
// What this block does
// - unlock needs 0x02 then 0x01 to control
// - once unlocked, only system reset relocks
// - data register carries commands, addresses, data bytes
// - opcodes 06 read, 07 write, 08 page, 03 device erase
// - host talks only while target is halted
// - halted target lends reset and port pins
// - reset pin is only ever an input
// - select register picks 0x02 control, 0xb4 data
// - host clock line plus one two-way data line
package twfp_pkg;
	// unlock pair and link register selects
	localparam logic [7:0] UNLOCK_FIRST = 8'h02;
	localparam logic [7:0] UNLOCK_SECOND = 8'h01;
	localparam logic [7:0] SEL_PART_ID = 8'h00;
	localparam logic [7:0] SEL_REV_ID = 8'h01;
	localparam logic [7:0] SEL_CTRL = 8'h02;
	localparam logic [7:0] SEL_DATA = 8'hb4;
	// identity values are arbitrary
	localparam logic [7:0] PART_ID_VALUE = 8'h5a;
	localparam logic [7:0] REV_ID_VALUE = 8'h00;
	// flash command opcodes
	localparam logic [7:0] OPC_BLOCK_READ = 8'h06;
	localparam logic [7:0] OPC_BLOCK_WRITE = 8'h07;
	localparam logic [7:0] OPC_PAGE_ERASE = 8'h08;
	localparam logic [7:0] OPC_DEVICE_ERASE = 8'h03;
	localparam logic [8:0] BLOCK_FULL = 9'h100;
	// control register read-back bits
	localparam int CTRL_UNLOCK_BIT = 0;
	localparam int CTRL_BUSY_BIT = 1;
	// link instructions, bit 0 set means host writes
	localparam logic [1:0] INS_DATA_READ = 2'h0;
	localparam logic [1:0] INS_DATA_WRITE = 2'h1;
	localparam logic [1:0] INS_ADDR_READ = 2'h2;
	localparam logic [1:0] INS_ADDR_WRITE = 2'h3;
	localparam logic [3:0] FRAME_BITS = 4'hb;
	localparam logic [3:0] INS_BITS = 4'h2;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// link clock half period
	localparam int MCLK_NS = 10;
	localparam int LINK_HALF_NS = 80;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS + MCLK_NS - 1) / MCLK_NS;
	localparam logic [3:0] HALF_LAST = 4'(LINK_HALF_CYC - 1);
	// host avalon register map
	localparam logic [3:0] HREG_CMD = 4'h0;
	localparam logic [3:0] HREG_STATUS = 4'h4;
	localparam logic [3:0] HREG_RDATA = 4'h8;
	localparam int HSTAT_BUSY_BIT = 0;
	localparam int HSTAT_HALTED_BIT = 1;
	localparam int HCMD_INS_LSB = 8;
	typedef enum logic [1:0] {TWFP_OP_READ, TWFP_OP_WRITE, TWFP_OP_PAGE_ERASE, TWFP_OP_DEV_ERASE} twfp_op_t;
endpackage

// ===== hdl/twfp_link_if.sv
// Purpose: two-wire link between programming host and target
// Assumes: data line idles high through a pull-up
// Notes: line level resolved here from the two enables
`timescale 1ns/1ps
interface twfp_link_if;
	logic link_clock_line;
	logic host_dout;
	logic host_oe;
	logic dev_dout;
	logic dev_oe;
	wire link_data_line;
	assign link_data_line = host_oe ? host_dout : (dev_oe ? dev_dout : 1'b1);
	modport host (output link_clock_line, output host_dout, output host_oe, input link_data_line);
	modport device (input link_clock_line, input link_data_line, output dev_dout, output dev_oe);
endinterface

// ===== hdl/twfp_sync.sv
// Purpose: two-flop synchroniser for one pin
// Assumes: idle level of the pin given by INIT
// Notes: first flop feeds only the second
`timescale 1ns/1ps
module twfp_sync #(
	parameter logic INIT = 1'b1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// pin in, synchronised out
	input wire logic din,
	output logic dout
);
	logic meta_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= INIT;
			dout <= INIT;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule

// ===== hdl/twfp_host.sv
// Purpose: programming host end, avalon-mm slave driving the two-wire link
// Assumes: target_halted comes from the target's clock domain
// Notes: one frame per command write; poll busy before reading rx data
`timescale 1ns/1ps
module twfp_host (
	// link pins
	twfp_link_if.host link,
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// target state
	input wire logic target_halted,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import twfp_pkg::*;

	typedef enum logic {TWFP_H_IDLE, TWFP_H_RUN} twfp_hst_t;

	twfp_hst_t st_q;
	logic halted_s;
	logic dat_s;
	logic [3:0] div_q;
	logic clk_q;
	logic oe_q;
	logic do_q;
	logic [9:0] sh_q;
	logic [7:0] rx_q;
	logic [3:0] bcnt_q;
	logic rd_q;
	logic pend_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [31:0] status_rd;

	twfp_sync #(.INIT(1'b0)) u_halt_sync (.mclk(mclk), .rst_b(rst_b), .din(target_halted), .dout(halted_s));
	twfp_sync #(.INIT(1'b1)) u_dat_sync (.mclk(mclk), .rst_b(rst_b), .din(link.link_data_line), .dout(dat_s));

	wire tick = (div_q == HALF_LAST);
	wire busy = pend_q | (st_q != TWFP_H_IDLE);
	wire sel_cmd = (avs_address == HREG_CMD);
	wire sel_status = (avs_address == HREG_STATUS);
	wire sel_rdata = (avs_address == HREG_RDATA);
	// unlock pair, select and flash bytes all go out as single frames
	wire cmd_take = avs_write & sel_cmd & ~busy;
	wire rx_phase = rd_q && (bcnt_q <= BYTE_BITS);

	always_comb begin
		status_rd = 32'h0000_0000;
		status_rd[HSTAT_BUSY_BIT] = busy;
		status_rd[HSTAT_HALTED_BIT] = halted_s;
	end

	wire [31:0] rd_mux = sel_status ? status_rd : (sel_rdata ? {24'h00_0000, rx_q} : 32'h0000_0000);

	assign avs_waitrequest = (avs_read & ~rvalid_q) | (avs_write & sel_cmd & busy);
	assign avs_readdata = rdata_q;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			div_q <= 4'h0;
		end else begin
			rvalid_q <= avs_read & ~rvalid_q;
			if (avs_read & ~rvalid_q) begin
				rdata_q <= rd_mux;
			end
			div_q <= tick ? 4'h0 : 4'(div_q + 4'h1);
		end
	end

	// clock line is only driven from here, never sampled
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= TWFP_H_IDLE;
			clk_q <= 1'b1;
			oe_q <= 1'b0;
			do_q <= 1'b1;
			sh_q <= 10'h000;
			rx_q <= 8'h00;
			bcnt_q <= 4'h0;
			rd_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			if (cmd_take) begin
				pend_q <= 1'b1;
				sh_q <= avs_writedata[9:0];
				rd_q <= ~avs_writedata[HCMD_INS_LSB];
			end
			case (st_q)
				TWFP_H_IDLE: begin
					// frames wait until the target reports halted
					if (tick && pend_q && halted_s) begin
						clk_q <= 1'b0;
						oe_q <= 1'b1;
						do_q <= 1'b0;
						bcnt_q <= FRAME_BITS;
						pend_q <= 1'b0;
						st_q <= TWFP_H_RUN;
					end
				end
				default: begin
					if (tick && !clk_q) begin
						clk_q <= 1'b1;
						bcnt_q <= bcnt_q - 4'h1;
						if (rx_phase) begin
							rx_q <= {rx_q[6:0], dat_s};
						end
					end else if (tick && (bcnt_q == 4'h0)) begin
						oe_q <= 1'b0;
						st_q <= TWFP_H_IDLE;
					end else if (tick) begin
						clk_q <= 1'b0;
						// hand the line to the target for the read byte
						if (rx_phase) begin
							oe_q <= 1'b0;
						end else begin
							oe_q <= 1'b1;
							do_q <= sh_q[9];
							sh_q <= {sh_q[8:0], 1'b0};
						end
					end
				end
			endcase
		end
	end

	assign link.link_clock_line = clk_q;
	assign link.host_dout = do_q;
	assign link.host_oe = oe_q;
endmodule

// ===== tb/twfp_link_assertions.sv
// Purpose: wire-level checks on the two-wire link
// Assumes: both ends on one mclk, link half period of eight mclk
// Notes: sees interface signals only
`timescale 1ns/1ps
module twfp_link_assertions (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// link signals
	input wire logic link_clock_line,
	input wire logic host_dout,
	input wire logic host_oe,
	input wire logic dev_dout,
	input wire logic dev_oe,
	input wire logic link_data_line
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// one half of the link clock
	sequence low_half;
		(!link_clock_line) [*8];
	endsequence
	sequence high_half;
		link_clock_line [*8];
	endsequence
	AST_ONE_DRIVER: assert property (!(host_oe && dev_oe))
		else $error("both ends drive the data line");
	AST_LOW_HALF: assert property ($fell(link_clock_line) |-> low_half ##1 link_clock_line)
		else $error("link clock low half not eight cycles");
	AST_HIGH_HALF: assert property ($rose(link_clock_line) |-> high_half)
		else $error("link clock high half too short");
	AST_START_BIT: assert property ($rose(host_oe) |-> !host_dout && $fell(link_clock_line))
		else $error("frame start not a low bit at a clock fall");
	AST_HOST_EDGE: assert property (host_oe && $past(host_oe) && $changed(host_dout) |-> $fell(link_clock_line))
		else $error("host data moved away from a clock fall");
	AST_DEV_STABLE: assert property (dev_oe && $past(dev_oe) && $changed(dev_dout) |-> !link_clock_line)
		else $error("target data moved while clock high");
	AST_DEV_TURN: assert property ($rose(dev_oe) |-> !link_clock_line && !host_oe)
		else $error("target took the line at a wrong moment");
	AST_HOST_LEVEL: assert property (host_oe |-> link_data_line == host_dout)
		else $error("line does not follow host data");
	AST_IDLE_HIGH: assert property (!host_oe && !dev_oe |-> link_data_line)
		else $error("released line not high");
endmodule

// ===== tb/tb_top.sv
// Purpose: host and target joined over the link, driven over avalon
// Assumes: one cycle flash stand-in answering every request
// Notes: expected flash read data is address low byte xor 0x5c
`timescale 1ns/1ps
module tb_top;
	import twfp_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic halted = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic pins_borrowed;
	logic prog_unlocked;
	logic flash_req;
	twfp_op_t flash_op;
	logic [15:0] flash_addr;
	logic [7:0] flash_wdata;
	logic [7:0] flash_rdata = 8'h00;
	logic flash_ack = 1'b0;
	twfp_op_t last_op;
	logic [15:0] last_addr;
	logic [7:0] last_wdata;
	logic [31:0] rd;
	int reqs = 0;
	int cycles = 0;
	int num_errors = 0;
	int samples_checked = 0;
	// no application driver on the data pin: only host and target drive it
	twfp_link_if lnk();
	always #5 mclk = ~mclk;
	twfp_host i_twfp_host (.link(lnk.host), .mclk(mclk), .rst_b(rst_b), .target_halted(halted),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	twfp_device i_twfp_device (.link(lnk.device), .mclk(mclk), .rst_b(rst_b), .halted(halted),
		.pins_borrowed(pins_borrowed), .prog_unlocked(prog_unlocked), .flash_req(flash_req),
		.flash_op(flash_op), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
		.flash_rdata(flash_rdata), .flash_ack(flash_ack));
	twfp_link_assertions i_chk (.mclk(mclk), .rst_b(rst_b), .link_clock_line(lnk.link_clock_line),
		.host_dout(lnk.host_dout), .host_oe(lnk.host_oe), .dev_dout(lnk.dev_dout),
		.dev_oe(lnk.dev_oe), .link_data_line(lnk.link_data_line));
	// flash stand-in, records each request
	always @(posedge mclk) begin
		flash_ack <= flash_req;
		flash_rdata <= flash_addr[7:0] ^ 8'h5c;
		cycles <= cycles + 1;
		if (flash_req === 1'b1) begin
			reqs <= reqs + 1;
			last_op <= flash_op;
			last_addr <= flash_addr;
			last_wdata <= flash_wdata;
		end
		if (cycles == 30000) begin
			num_errors++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	// one link frame, then poll until idle
	task link(input logic [1:0] ins, input logic [7:0] b);
		av(1'b1, HREG_CMD, {22'h0, ins, b});
		do av(1'b0, HREG_STATUS, 32'h0); while (rd[HSTAT_BUSY_BIT] !== 1'b0);
	endtask
	task rdl;
		link(INS_DATA_READ, 8'h00);
		av(1'b0, HREG_RDATA, 32'h0);
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		chk(lnk.link_clock_line, 1);
		av(1'b0, HREG_STATUS, 32'h0);
		chk(rd[HSTAT_HALTED_BIT], 0);
		// a frame asked for before the halt must wait for it; a free-running one ends well inside 250
		av(1'b1, HREG_CMD, {22'h0, INS_ADDR_WRITE, SEL_REV_ID});
		repeat (250) @(posedge mclk);
		chk(lnk.link_clock_line, 32'h1);
		av(1'b0, HREG_STATUS, 32'h0);
		chk(rd[HSTAT_BUSY_BIT], 32'h1);
		halted <= 1'b1;
		repeat (4) @(posedge mclk);
		chk(pins_borrowed, 1);
		do av(1'b0, HREG_STATUS, 32'h0); while (rd[HSTAT_BUSY_BIT] !== 1'b0);
		chk(rd[HSTAT_HALTED_BIT], 32'h1);
		// the held frame landed once halted: select reads back
		link(INS_ADDR_READ, 8'h00);
		av(1'b0, HREG_RDATA, 32'h0);
		chk(rd[7:0], SEL_REV_ID);
		rdl();
		chk(rd[7:0], REV_ID_VALUE);
		av(1'b0, 4'hc, 32'h0);
		chk(rd, 0);
		link(INS_ADDR_WRITE, SEL_DATA);
		link(INS_DATA_WRITE, OPC_DEVICE_ERASE);
		repeat (8) @(posedge mclk);
		chk(reqs, 0);
		link(INS_ADDR_WRITE, SEL_CTRL);
		link(INS_DATA_WRITE, 8'h01);
		link(INS_DATA_WRITE, 8'h02);
		link(INS_DATA_WRITE, 8'h05);
		link(INS_DATA_WRITE, 8'h01);
		chk(prog_unlocked, 0);
		link(INS_DATA_WRITE, UNLOCK_FIRST);
		link(INS_DATA_WRITE, UNLOCK_SECOND);
		chk(prog_unlocked, 1);
		rdl();
		chk(rd[CTRL_UNLOCK_BIT], 1);
		link(INS_ADDR_WRITE, SEL_PART_ID);
		rdl();
		chk(rd[7:0], PART_ID_VALUE);
		link(INS_ADDR_WRITE, SEL_DATA);
		link(INS_DATA_WRITE, OPC_DEVICE_ERASE);
		repeat (8) @(posedge mclk);
		chk(32'(last_op), 32'(TWFP_OP_DEV_ERASE));
		link(INS_DATA_WRITE, OPC_PAGE_ERASE);
		link(INS_DATA_WRITE, 8'h12);
		link(INS_DATA_WRITE, 8'h34);
		repeat (8) @(posedge mclk);
		chk(32'(last_op), 32'(TWFP_OP_PAGE_ERASE));
		chk(last_addr, 16'h1234);
		// write across a low-byte carry
		link(INS_DATA_WRITE, OPC_BLOCK_WRITE);
		link(INS_DATA_WRITE, 8'h00);
		link(INS_DATA_WRITE, 8'hff);
		link(INS_DATA_WRITE, 8'h02);
		link(INS_DATA_WRITE, 8'ha5);
		link(INS_DATA_WRITE, 8'h3c);
		repeat (8) @(posedge mclk);
		chk(reqs, 4);
		chk(32'(last_op), 32'(TWFP_OP_WRITE));
		chk(last_addr, 16'h0100);
		chk(last_wdata, 8'h3c);
		link(INS_DATA_WRITE, OPC_BLOCK_READ);
		link(INS_DATA_WRITE, 8'h00);
		link(INS_DATA_WRITE, 8'h20);
		link(INS_DATA_WRITE, 8'h02);
		rdl();
		chk(rd[7:0], 8'h7c);
		rdl();
		chk(rd[7:0], 8'h7d);
		// control writes after unlock change nothing
		link(INS_ADDR_WRITE, SEL_CTRL);
		link(INS_DATA_WRITE, 8'h00);
		rdl();
		chk(rd[CTRL_UNLOCK_BIT], 1);
		rst_b <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		chk(prog_unlocked, 0);
		chk(lnk.link_data_line, 32'h1);
		halted <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(pins_borrowed, 0);
		end_of_test();
	end
endmodule
